// >>> rtl/irq_trap_ctrl.sv
// Purpose: Interrupt, trap, stack pointer and control register logic
// Assumes: Core signals are synchronous; instr_boundary marks instruction ends
// Notes:   Registers reached over AXI4-Lite, 8-bit data in the low byte
`timescale 1ns/1ps
module irq_trap_ctrl
	import irq_trap_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Event sources
	input  wire logic        port_g_bit_zero,
	input  wire logic        timer_underflow,
	input  wire logic        timer_capture,
	input  wire logic        serial_busy,
	// Core sequencer
	input  wire logic        instr_boundary,
	input  wire logic [14:0] current_pc,
	input  wire logic        fetch_strobe,
	input  wire logic [14:0] fetch_addr,
	input  wire logic [7:0]  rom_data,
	input  wire logic        call_push,
	input  wire logic        return_from_irq,
	input  wire logic        plain_return,
	input  wire logic        return_and_skip,
	input  wire logic [14:0] pop_value,
	// Data memory read path
	input  wire logic [7:0]  ram_addr,
	input  wire logic [7:0]  ram_raw_data,
	output logic [7:0]       ram_read_data,
	// Core commands
	output logic             irq_ack,
	output logic             trap_ack,
	output logic             push_req,
	output logic [14:0]      push_value,
	output logic             pc_load,
	output logic [14:0]      pc_value,
	output logic [7:0]       stack_pointer,
	// Timer and port G
	output logic             timer_run,
	input  wire logic        shift_clock,
	input  wire logic        serial_data_out,
	input  wire logic        port_g_bit_five_data,
	input  wire logic        port_g_bit_four_data,
	output logic             port_g_bit_three,
	output logic             port_g_bit_four,
	output logic             port_g_bit_five
);
	typedef struct packed {
		logic [7:0]  ctrl;        // Timer/serial control
		logic        genb;        // Global enable
		logic        pen;         // Pin enable
		logic        ten;         // Timer enable
		logic        ppend;       // Pin pending
		logic        tpend;       // Timer pending
		logic        carry;       // Carry
		logic        hcarry;      // Half carry
		logic [7:0]  ptr;         // Stack pointer
		logic        aw_got;      // Write address held
		logic        w_got;       // Write data held
		logic [11:0] awaddr;      // Held write address
		logic [7:0]  wdata;       // Held write byte
		logic        wlane;       // Low byte lane enabled
		logic        awready;     // Bus handshake outputs
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [7:0]  rdata;
		logic        irq_ack;     // Core command pulses and values
		logic        trap_ack;
		logic        push;
		logic        pc_load;
		logic [14:0] push_value;
		logic [14:0] pc_value;
		logic        pin3;        // Port G outputs
		logic        pin4;
		logic        pin5;
		logic [7:0]  ram_data;    // Filtered data memory read
	} state_t;

	state_t s_r;   // Registered state
	state_t s_nxt; // Next state

	logic       pin_edge;     // Selected edge on the pin
	logic       timer_event;  // Mode-selected timer event
	logic [7:0] fetched_op;   // Opcode after range check
	logic       hw_take;      // Hardware interrupt accepted
	logic       trap_take;    // Software trap accepted
	logic [7:0] status_rd;    // Status word as read
	logic       wr_fire;      // Write performed this cycle
	logic       wr_hit_tsc;   // Write hits control register
	logic       wr_hit_sw;    // Write hits status word

	// Edge detector on the external pin
	pin_edge_detect u_pin_edge (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.pin_level  (port_g_bit_zero),
		.rising_sel (s_r.ctrl[CTL_EDGE]),
		.edge_hit   (pin_edge)
	);

	// Capture modes flag the capture edge, others the underflow
	assign timer_event = (s_r.ctrl[CTL_MODE_HI -: 2] == MODE_CAPTURE) ? timer_capture // see [R2]
	                                                                   : timer_underflow;
	// Missing ROM reads as zero, which is the trap opcode
	assign fetched_op  = (fetch_addr >= ROM_LIMIT) ? TRAP_OPCODE : rom_data; // see [R13]
	// Hardware wins only at boundaries, gated by both enables
	assign hw_take     = instr_boundary & s_r.genb &
	                     ((s_r.pen & s_r.ppend) | (s_r.ten & s_r.tpend)); // see [R4] [R21]
	// Trap only with nothing pending; a same-cycle hardware take drops it
	assign trap_take   = fetch_strobe & (fetched_op == TRAP_OPCODE) &
	                     ~s_r.ppend & ~s_r.tpend & ~hw_take; // see [R3] [R11] [R12]
	// Status word order, busy comes from the serial unit
	assign status_rd   = {s_r.hcarry, s_r.carry, s_r.tpend, s_r.ten,
	                      s_r.ppend, serial_busy, s_r.pen, s_r.genb}; // see [R20]
	assign wr_fire     = s_r.aw_got & s_r.w_got & ~s_r.bvalid;
	assign wr_hit_tsc  = s_r.awaddr == TSC_ADDR;
	assign wr_hit_sw   = s_r.awaddr == STATUS_ADDR;

	// Next state: bus first, then hardware events override
	always_comb begin
		s_nxt          = s_r;
		s_nxt.irq_ack  = 1'b0;
		s_nxt.trap_ack = 1'b0;
		s_nxt.push     = 1'b0;
		s_nxt.pc_load  = 1'b0;

		// Capture write address and data in any order
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata[7:0];
			s_nxt.wlane = s_axi_wstrb[0];
		end
		// Perform the write once both halves are held
		if (wr_fire) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = (wr_hit_tsc || wr_hit_sw) ? RESP_OKAY : RESP_SLVERR;
			if (s_r.wlane && wr_hit_tsc) begin
				s_nxt.ctrl = s_r.wdata; // see [R16]
			end
			if (s_r.wlane && wr_hit_sw) begin
				s_nxt.genb   = s_r.wdata[SW_GEN];
				s_nxt.pen    = s_r.wdata[SW_PEN];
				s_nxt.ppend  = s_r.wdata[SW_PPEND]; // see [R6]
				s_nxt.ten    = s_r.wdata[SW_TEN];
				s_nxt.tpend  = s_r.wdata[SW_TPEND]; // see [R6]
				s_nxt.carry  = s_r.wdata[SW_CARRY];
				s_nxt.hcarry = s_r.wdata[SW_HCARRY];
			end
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		// One write in flight: stop taking halves until response goes
		s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
		s_nxt.wready  = ~s_nxt.w_got & ~s_nxt.bvalid;

		// Reads answer one cycle after the address is taken
		if (s_axi_arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			if (s_axi_araddr == TSC_ADDR) begin
				s_nxt.rdata = s_r.ctrl;
				s_nxt.rresp = RESP_OKAY;
			end else if (s_axi_araddr == STATUS_ADDR) begin
				s_nxt.rdata = status_rd;
				s_nxt.rresp = RESP_OKAY;
			end else begin
				s_nxt.rdata = '0;
				s_nxt.rresp = RESP_SLVERR;
			end
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		s_nxt.arready = ~s_nxt.rvalid;

		// Events set flags whatever the enables; set beats a clear
		if (pin_edge) begin
			s_nxt.ppend = 1'b1; // see [R1] [R21]
		end
		if (timer_event) begin
			s_nxt.tpend = 1'b1; // see [R2] [R21]
		end

		// Stack pointer moves for calls and returns
		if (call_push) begin
			s_nxt.ptr = s_r.ptr - PTR_STEP; // see [R15]
		end
		if (plain_return || return_and_skip || return_from_irq) begin
			s_nxt.ptr     = s_r.ptr + PTR_STEP; // see [R15]
			s_nxt.pc_load = 1'b1;
			s_nxt.pc_value = return_and_skip ? pop_value + SKIP_STEP : pop_value;
		end
		if (return_from_irq) begin
			s_nxt.genb = 1'b1; // see [R8]
		end

		// Hardware acknowledge: push PC, drop enable, go to vector
		if (hw_take) begin
			s_nxt.irq_ack    = 1'b1;
			s_nxt.push       = 1'b1;
			s_nxt.push_value = current_pc;  // see [R7]
			s_nxt.genb       = 1'b0;        // see [R7]
			s_nxt.ptr        = s_r.ptr - PTR_STEP; // see [R15]
			s_nxt.pc_load    = 1'b1;
			s_nxt.pc_value   = IRQ_VECTOR;  // see [R7]
		end else if (trap_take) begin
			// Trap keeps its own address and leaves the enable alone
			s_nxt.trap_ack   = 1'b1;
			s_nxt.push       = 1'b1;
			s_nxt.push_value = fetch_addr;  // see [R10]
			s_nxt.ptr        = s_r.ptr - PTR_STEP; // see [R15]
			s_nxt.pc_load    = 1'b1;
			s_nxt.pc_value   = IRQ_VECTOR;  // see [R3] [R9]
		end

		// Counting mode underflow toggles the pin output
		if (timer_underflow && s_r.ctrl[CTL_RUN] &&
		    s_r.ctrl[CTL_MODE_HI:CTL_MODE_LO] == MODE_PWM_TOGGLE) begin
			s_nxt.pin3 = ~s_r.pin3; // see [R19]
		end
		// Serial select routes shift clock and data onto the pins
		s_nxt.pin5 = s_r.ctrl[CTL_SERSEL] ? shift_clock : port_g_bit_five_data;     // see [R18]
		s_nxt.pin4 = s_r.ctrl[CTL_SERSEL] ? serial_data_out : port_g_bit_four_data; // see [R18]

		// Unused RAM gap reads as all ones
		s_nxt.ram_data = (ram_addr >= RAM_GAP_LO && ram_addr <= RAM_GAP_HI) ?
		                 RAM_ALL_ONES : ram_raw_data; // see [R14]
	end

	// Synchronous reset; ready outputs come up high so the bus can start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r         <= '0;
			s_r.ctrl    <= TSC_RESET;
			s_r.ptr     <= PTR_RESET;
			s_r.awready <= 1'b1;
			s_r.wready  <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign s_axi_awready    = s_r.awready;
	assign s_axi_wready     = s_r.wready;
	assign s_axi_bvalid     = s_r.bvalid;
	assign s_axi_bresp      = s_r.bresp;
	assign s_axi_arready    = s_r.arready;
	assign s_axi_rvalid     = s_r.rvalid;
	assign s_axi_rdata      = {24'h00_0000, s_r.rdata};
	assign s_axi_rresp      = s_r.rresp;
	assign ram_read_data    = s_r.ram_data;
	assign irq_ack          = s_r.irq_ack;
	assign trap_ack         = s_r.trap_ack;
	assign push_req         = s_r.push;
	assign push_value       = s_r.push_value;
	assign pc_load          = s_r.pc_load;
	assign pc_value         = s_r.pc_value;
	assign stack_pointer    = s_r.ptr;
	assign timer_run        = s_r.ctrl[CTL_RUN]; // see [R17]
	assign port_g_bit_three = s_r.pin3;
	assign port_g_bit_four  = s_r.pin4;
	assign port_g_bit_five  = s_r.pin5;

	// Acknowledge clears enable and vectors next cycle
	hw_ack_vector_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R7]
		hw_take |=> (irq_ack && !s_r.genb && pc_load && pc_value == IRQ_VECTOR && push_req))
		else $error("hardware acknowledge did not vector");
	// Acknowledge only with both enables
	hw_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R4]
		$rose(irq_ack) |-> $past(s_r.genb) && ($past(s_r.pen & s_r.ppend) || $past(s_r.ten & s_r.tpend)))
		else $error("acknowledge without enables");
	// Trap keeps the enable
	trap_keeps_gie_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R9]
		trap_take && !return_from_irq && !wr_fire |=> s_r.genb == $past(s_r.genb))
		else $error("trap changed global enable");
	// Trap pushes its own address
	trap_own_addr_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R10]
		trap_take |=> trap_ack && push_value == $past(fetch_addr))
		else $error("trap pushed wrong address");
	// Pending or simultaneous hardware blocks the trap
	trap_blocked_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R11]
		(s_r.ppend || s_r.tpend || hw_take) |=> !trap_ack)
		else $error("trap taken over hardware");
	// Pin edge always lands in the flag
	pin_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R1]
		pin_edge |=> s_r.ppend)
		else $error("pin edge lost");
	// Return from interrupt restores enable and pops
	return_from_irq_restore_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R8]
		return_from_irq && !hw_take |=> s_r.genb && pc_load && s_r.ptr == $past(s_r.ptr) + PTR_STEP)
		else $error("return did not restore");
	// Fetch past ROM end traps when idle
	rom_end_trap_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R13]
		fetch_strobe && fetch_addr >= ROM_LIMIT && !s_r.ppend && !s_r.tpend && !hw_take |=> trap_ack)
		else $error("missing ROM did not trap");
	// Unused RAM gap reads ones
	ram_gap_ones_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R14]
		ram_addr >= RAM_GAP_LO && ram_addr <= RAM_GAP_HI |=> ram_read_data == RAM_ALL_ONES)
		else $error("ram gap not all ones");
	// Serial select steers pin five
	serial_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R18]
		s_r.ctrl[CTL_SERSEL] |=> port_g_bit_five == $past(shift_clock))
		else $error("shift clock not routed");
endmodule

// >>> rtl/irq_trap_pkg.sv
// Purpose: Shared constants for the interrupt and trap control block
// Assumes: One 10 MHz instruction-cycle clock, AXI4-Lite register access
// Notes:   Register offsets are indices; byte address is four times the index
// What this block does
// [R1] Pin edge on port G bit zero raises request
// [R2] Timer underflow or capture raises timer request
// [R3] Fetched opcode zero takes non-maskable trap
// [R4] Hardware source needs global and own enable
// [R5] Edge select: one rising, zero falling
// [R6] Separate pending flags; software clears serviced one
// [R7] Acknowledge pushes PC, clears enable, vectors
// [R8] Return-from-interrupt pops PC, sets global enable
// [R9] Trap leaves global enable unchanged
// [R10] Trap stacks its own address
// [R11] Trap only when no hardware flag pending
// [R12] Simultaneous trap lost, hardware interrupt wins
// [R13] Program fetch at or above limit reads zero
// [R14] Unimplemented data memory reads all ones
// [R15] Stack pointer down on push, up on pop
// [R16] Control register bit layout, mode in 7:5
// [R17] Run bit starts and stops timer
// [R18] Serial select puts shift clock, data on G
// [R19] Counting mode underflow toggles port G bit three
// [R20] Status word at 00EF with fixed bit order
// [R21] Flags set while disabled; acknowledge at boundaries
package irq_trap_pkg;
	// Register indices and byte addresses
	localparam logic [7:0]  TSC_INDEX      = 8'hEE;
	localparam logic [7:0]  STATUS_INDEX   = 8'hEF;
	localparam logic [11:0] TSC_ADDR       = {2'b00, TSC_INDEX, 2'b00};
	localparam logic [11:0] STATUS_ADDR    = {2'b00, STATUS_INDEX, 2'b00};
	// Control register fields
	localparam int          CTL_MODE_HI    = 7;
	localparam int          CTL_MODE_LO    = 5;
	localparam int          CTL_RUN        = 4;
	localparam int          CTL_SERSEL     = 3;
	localparam int          CTL_EDGE       = 2;
	// Status word fields
	localparam int          SW_GEN         = 0;
	localparam int          SW_PEN         = 1;
	localparam int          SW_BUSY        = 2;
	localparam int          SW_PPEND       = 3;
	localparam int          SW_TEN         = 4;
	localparam int          SW_TPEND       = 5;
	localparam int          SW_CARRY       = 6;
	localparam int          SW_HCARRY      = 7;
	// Timer modes
	localparam logic [2:0]  MODE_PWM_TOGGLE = 3'h5;
	localparam logic [1:0]  MODE_CAPTURE    = 2'h3;
	// Core side constants
	localparam logic [14:0] IRQ_VECTOR     = 15'h00FF;
	localparam logic [14:0] ROM_LIMIT      = 15'h0300;
	localparam logic [7:0]  TRAP_OPCODE    = 8'h00;
	localparam logic [7:0]  RAM_GAP_LO     = 8'h30;
	localparam logic [7:0]  RAM_GAP_HI     = 8'h7F;
	localparam logic [7:0]  RAM_ALL_ONES   = 8'hFF;
	localparam logic [7:0]  PTR_STEP       = 8'h02;
	localparam logic [14:0] SKIP_STEP      = 15'h0001;
	// Reset values
	localparam logic [7:0]  TSC_RESET      = 8'h00;
	localparam logic [7:0]  PTR_RESET      = 8'h2F;
	// AXI responses
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// >>> rtl/pin_edge_detect.sv
// Purpose: Selectable edge detector for a synchronous pin
// Assumes: Pin already synchronous to aclk
// Notes:   Output is combinational from the stored previous level
`timescale 1ns/1ps
module pin_edge_detect
	import irq_trap_pkg::*;
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Pin and edge choice
	input  wire logic pin_level,
	input  wire logic rising_sel,
	// Detected edge
	output logic      edge_hit
);
	typedef struct packed {
		logic prev;   // Level seen last cycle
	} edge_state_t;

	edge_state_t s_r;   // Stored state
	edge_state_t s_nxt; // Next state

	// Next state is just the current pin level
	always_comb begin
		s_nxt      = s_r;
		s_nxt.prev = pin_level;
	end

	// Reset low; falling edge is the reset choice, so a high pin gives no false edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Rising when one, falling when zero
	assign edge_hit = rising_sel ? (pin_level & ~s_r.prev)   // see [R5]
	                             : (~pin_level & s_r.prev);  // see [R5]
endmodule

// >>> tb/core_stack_model.sv
// Purpose: Stack memory of the core, serving the block's pushes and pops
// Assumes: A push lands at the already lowered stack pointer
// Notes:   Untouched cells read as all ones, like unused data memory
`timescale 1ns/1ps
module core_stack_model (
	// Clock
	input  wire logic        aclk,
	// Stack traffic from the block
	input  wire logic        push_req,
	input  wire logic [14:0] push_value,
	input  wire logic [7:0]  stack_pointer,
	// Popped return address
	output logic      [14:0] pop_value
);
	// One cell per stack pointer value
	logic [14:0] mem [256];
	// Unused cells give all ones, so an over-pop returns to the top address
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 15'h7fff;
		end
	end
	// Push stores at the lowered pointer, so a pop reads where it stands
	always @(posedge aclk) begin
		if (push_req) begin
			mem[stack_pointer] <= push_value;
		end
	end
	// Pop address follows the pointer, which moves up after each return
	assign pop_value = mem[stack_pointer];
endmodule

// >>> tb/test_interrupt_and_trap_control.sv
// Purpose: Self-checking bench for the interrupt and trap block
// Assumes: Register bus answers whenever it likes; bench only waits
// Notes:   Bus and core results are noted in queues and compared on arrival
`timescale 1ns/1ps
module test_interrupt_and_trap_control;
	import irq_trap_pkg::*;
	// Bus and core signals, named as the ports
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        port_g_bit_zero, timer_underflow, timer_capture, serial_busy, instr_boundary, fetch_strobe;
	logic        call_push, return_from_irq, plain_return, return_and_skip, shift_clock, serial_data_out;
	logic        port_g_bit_five_data, port_g_bit_four_data, irq_ack, trap_ack, push_req, pc_load, timer_run;
	logic        port_g_bit_three, port_g_bit_four, port_g_bit_five;
	logic [14:0] current_pc, fetch_addr, pop_value, push_value, pc_value, pc1, adr;
	logic [7:0]  rom_data, ram_addr, ram_raw_data, ram_read_data, stack_pointer, op;
	// Expected bus answers and core events, oldest first
	logic [33:0] bq [$];
	logic [16:0] cq [$];
	logic [33:0] seen;
	int          fail_count = 0;
	int          tests_run = 0;
	int          seed = 44;
	// Block and the core's stack beside it
	irq_trap_ctrl i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .port_g_bit_zero,
		.timer_underflow, .timer_capture, .serial_busy, .instr_boundary, .current_pc, .fetch_strobe, .fetch_addr,
		.rom_data, .call_push, .return_from_irq, .plain_return, .return_and_skip, .pop_value, .ram_addr,
		.ram_raw_data, .ram_read_data, .irq_ack, .trap_ack, .push_req, .push_value, .pc_load, .pc_value,
		.stack_pointer, .timer_run, .shift_clock, .serial_data_out, .port_g_bit_five_data, .port_g_bit_four_data,
		.port_g_bit_three, .port_g_bit_four, .port_g_bit_five);
	core_stack_model i_core (.aclk, .push_req, .push_value, .stack_pointer, .pop_value);
	// 10 MHz clock
	initial aclk = 1'b0;
	always #50 aclk = ~aclk;
	// Compare and count
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask
	// Single closing point
	task automatic print_verdict;
		if (fail_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back({r, 32'h0000_0000});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	// Read: rready held until the answer is sampled
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		bq.push_back(e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
	// Status word shorthands
	task automatic ws(input logic [7:0] v);
		wr(STATUS_ADDR, {24'h00_0000, v}, RESP_OKAY);
	endtask
	task automatic rs(input logic [7:0] v);
		rd(STATUS_ADDR, {RESP_OKAY, 24'h00_0000, v});
	endtask
	// One-cycle strobes: boundary, fetch, three returns, call, underflow, capture
	task automatic cyc(input logic [7:0] s, input logic [14:0] a, input logic [7:0] o);
		@(posedge aclk);
		{instr_boundary, fetch_strobe, return_from_irq, plain_return, return_and_skip, call_push,
			timer_underflow, timer_capture} <= s;
		current_pc <= a;
		fetch_addr <= a;
		rom_data <= o;
		@(posedge aclk);
		{instr_boundary, fetch_strobe, return_from_irq, plain_return, return_and_skip, call_push,
			timer_underflow, timer_capture} <= 8'h00;
		repeat (3) @(posedge aclk);
	endtask
	// Data memory read, registered one cycle
	task automatic ram(input logic [7:0] a, input logic [7:0] e);
		ram_addr <= a;
		ram_raw_data <= 8'h5a;
		repeat (2) @(posedge aclk);
		check(ram_read_data, e);
	endtask
	// Monitor takes the oldest note whenever a result appears
	always @(posedge aclk) begin
		if (aresetn && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))) begin
			seen = s_axi_bvalid ? {s_axi_bresp, 32'h0000_0000} : {s_axi_rresp, s_axi_rdata};
			if (bq.size() > 0) check(seen, bq.pop_front());
			else check(seen, 34'bx);
		end
		if (aresetn && pc_load) begin
			if (cq.size() > 0) check({irq_ack, trap_ack, pc_value}, cq.pop_front());
			else check({irq_ack, trap_ack, pc_value}, 34'bx);
		end
	end
	// Hang guard, far above the few hundred cycles needed
	initial begin
		repeat (3000) @(posedge aclk);
		fail_count++;
		print_verdict;
	end
	// Main sequence
	initial begin
		aresetn = 1'b0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, port_g_bit_zero, timer_underflow,
			timer_capture, serial_busy, instr_boundary, fetch_strobe, call_push, return_from_irq, plain_return,
			return_and_skip, shift_clock, serial_data_out, port_g_bit_five_data, port_g_bit_four_data} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, current_pc, fetch_addr, rom_data, ram_addr, ram_raw_data} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values and unmapped places
		rd(TSC_ADDR, {RESP_OKAY, 32'h0000_0000});
		rs(8'h00);
		rd(12'h000, {RESP_SLVERR, 32'h0000_0000});
		wr(12'h004, 32'h0000_0000, RESP_SLVERR);
		// Low byte lane off: answered but not applied
		s_axi_wstrb <= 4'he;
		wr(TSC_ADDR, 32'h0000_00ff, RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(TSC_ADDR, {RESP_OKAY, 32'h0000_0000});
		// Rising edge flags while disabled; no take without enables
		wr(TSC_ADDR, 32'h0000_0004, RESP_OKAY);
		port_g_bit_zero <= 1'b1;
		rs(8'h08);
		cyc(8'h80, 15'h0100, 8'h01);
		cyc(8'h40, 15'h0101, 8'h00);
		ws(8'h0b);
		pc1 = 15'($random(seed));
		cq.push_back({2'b10, IRQ_VECTOR});
		cyc(8'hc0, pc1, 8'h00);
		check(push_value, pc1);
		check(stack_pointer, PTR_RESET - PTR_STEP);
		rs(8'h0a);
		// Trap keeps global enable and stacks its own address
		ws(8'h01);
		adr = 15'($random(seed) & 32'h0000_01ff);
		cq.push_back({2'b01, IRQ_VECTOR});
		cyc(8'h40, adr, 8'h00);
		check(push_value, adr);
		rs(8'h01);
		ws(8'h00);
		cq.push_back({2'b00, adr + 15'h0001});
		cyc(8'h08, 15'h0000, 8'h01);
		cq.push_back({2'b00, pc1});
		cyc(8'h20, 15'h0000, 8'h01);
		rs(8'h01);
		check(stack_pointer, PTR_RESET);
		// Over-pop returns to all ones; fetch there traps
		cq.push_back({2'b00, 15'h7fff});
		cyc(8'h10, 15'h0000, 8'h01);
		op = 8'($random(seed)) | 8'h01;
		cq.push_back({2'b01, IRQ_VECTOR});
		cyc(8'h40, 15'h7fff, op);
		check(push_value, 15'h7fff);
		cyc(8'h40, ROM_LIMIT - 15'h0001, op);
		ram(8'h30, 8'hff);
		ram(8'h10, 8'h5a);
		// Timer source per mode, gated by the global enable
		ws(8'h10);
		wr(TSC_ADDR, 32'h0000_0080, RESP_OKAY);
		cyc(8'h01, 15'h0000, 8'h01);
		rs(8'h10);
		cyc(8'h02, 15'h0000, 8'h01);
		rs(8'h30);
		cyc(8'h80, 15'h0010, 8'h01);
		ws(8'h31);
		cq.push_back({2'b10, IRQ_VECTOR});
		cyc(8'h80, 15'h0011, 8'h01);
		rs(8'h30);
		wr(TSC_ADDR, 32'h0000_00c0, RESP_OKAY);
		ws(8'h10);
		cyc(8'h01, 15'h0000, 8'h01);
		rs(8'h30);
		// Run, serial pins and toggling output; pins settle one edge after the write
		{shift_clock, serial_data_out, port_g_bit_five_data, port_g_bit_four_data} <= 4'($random(seed));
		wr(TSC_ADDR, 32'h0000_00b8, RESP_OKAY);
		@(negedge aclk);
		check(timer_run, 1'b1);
		check({port_g_bit_five, port_g_bit_four}, {shift_clock, serial_data_out});
		cyc(8'h02, 15'h0000, 8'h01);
		check(port_g_bit_three, 1'b1);
		cyc(8'h02, 15'h0000, 8'h01);
		check(port_g_bit_three, 1'b0);
		wr(TSC_ADDR, 32'h0000_0000, RESP_OKAY);
		@(negedge aclk);
		check(timer_run, 1'b0);
		check({port_g_bit_five, port_g_bit_four}, {port_g_bit_five_data, port_g_bit_four_data});
		// Falling edge selected: fall flags, rise does not; carry bits kept
		ws(8'hc0);
		port_g_bit_zero <= 1'b0;
		cyc(8'h00, 15'h0000, 8'h01);
		rs(8'hc8);
		ws(8'h00);
		port_g_bit_zero <= 1'b1;
		serial_busy <= 1'b1;
		cyc(8'h00, 15'h0000, 8'h01);
		rs(8'h04);
		// Call moves the pointer down one more step
		cyc(8'h04, 15'h0000, 8'h01);
		check(stack_pointer, 8'h2b);
		check(bq.size() + cq.size(), 0);
		print_verdict;
	end
endmodule
